// ---- core/serial_rom_reader.sv ----
// Serial ROM single-word read engine with programmable serial clock half period
`timescale 1ns/100ps
module serial_rom_reader
  import strap_cfg_pkg::*;
(
  input  wire logic                     pclk,       // System clock
  input  wire logic                     presetn,    // Async reset, active low
  input  wire logic                     start,      // Begin one word read
  input  wire logic                     abort,      // Drop current read
  input  wire logic [ROM_ADDR_BITS-1:0] word_addr,  // Word address
  input  wire logic [9:0]               half_cycles,// Clocks per serial clock half
  input  wire logic                     din,        // Synchronised ROM data
  output logic                          sk,         // Serial clock
  output logic                          cs,         // Chip select
  output logic                          dout,       // Data to ROM
  output logic                          done,       // One-cycle completion pulse
  output logic [ROM_WORD_BITS-1:0]      data        // Word read
);

  rd_state_e                 state;
  logic [9:0]                phase_cnt;
  logic [4:0]                bit_cnt;
  logic [ROM_CMD_BITS-1:0]   tx;

  // Bit sequencer: command out on falling half, data sampled at end of high half
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= RD_IDLE;
      phase_cnt <= 10'h000;
      bit_cnt   <= 5'h00;
      tx        <= '0;
      sk        <= 1'b0;
      cs        <= 1'b0;
      dout      <= 1'b0;
      done      <= 1'b0;
      data      <= '0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        state <= RD_IDLE;
        sk    <= 1'b0;
        cs    <= 1'b0;
        dout  <= 1'b0;
      end else begin
        case (state)
          RD_IDLE: begin
            if (start) begin
              cs        <= 1'b1;
              sk        <= 1'b0;
              dout      <= ROM_READ_CMD[2];
              tx        <= {ROM_READ_CMD[1:0], word_addr, 1'b0};
              bit_cnt   <= 5'h00;
              phase_cnt <= half_cycles - 10'h001;
              state     <= RD_LOW;
            end
          end
          RD_LOW: begin
            if (phase_cnt == 10'h000) begin
              sk        <= 1'b1;
              phase_cnt <= half_cycles - 10'h001;
              state     <= RD_HIGH;
            end else begin
              phase_cnt <= phase_cnt - 10'h001;
            end
          end
          RD_HIGH: begin
            if (phase_cnt == 10'h000) begin
              sk <= 1'b0;
              if (bit_cnt >= 5'(ROM_CMD_BITS)) begin
                data <= {data[ROM_WORD_BITS-2:0], din};
              end
              if (bit_cnt == 5'(ROM_FRAME_BITS - 1)) begin
                cs    <= 1'b0;
                dout  <= 1'b0;
                done  <= 1'b1;
                state <= RD_IDLE;
              end else begin
                bit_cnt   <= bit_cnt + 5'h01;
                dout      <= tx[ROM_CMD_BITS-1];
                tx        <= {tx[ROM_CMD_BITS-2:0], 1'b0};
                phase_cnt <= half_cycles - 10'h001;
                state     <= RD_LOW;
              end
            end else begin
              phase_cnt <= phase_cnt - 10'h001;
            end
          end
          default: state <= RD_IDLE;
        endcase
      end
    end
  end

endmodule : serial_rom_reader

// ---- core/strap_and_eeprom_config.sv ----
// Strap latching, serial ROM configuration load, host strobe qualification and power-down
//
// Behaviour
// - Load from serial ROM only when its enable strap reads high.
// - Bus speed code 11 gives a 4 us serial clock cycle.
// - Bus speed code 00 gives an 800 ns serial clock cycle.
// - Serial data output pin feeds the ROM's data input during load.
// - Configuration bits come in on the serial data input pin.
// - Dedicated chip select output selects the ROM during accesses.
// - Serial clock pin level is latched at reset as endian selection.
// - Data input pin level is latched at reset as bus width selection.
// - Host qualifier low validates decodes; decodes ignored while it is high.
// - Power-down input low stops the chip; high or floating runs normally.
// - During power-down every pin output is released to high impedance.
`timescale 1ns/100ps
module strap_and_eeprom_config
  import strap_cfg_pkg::*;
(
  input  wire logic        pclk,                   // System clock, 250 MHz
  input  wire logic        presetn,                // Async reset, active low
  input  wire logic [11:0] paddr,                  // APB address
  input  wire logic        psel,                   // APB select
  input  wire logic        penable,                // APB enable
  input  wire logic        pwrite,                 // APB direction
  input  wire logic [31:0] pwdata,                 // APB write data
  output logic      [31:0] prdata,                 // APB read data
  output logic             pready,                 // APB ready
  output logic             pslverr,                // APB error
  input  wire logic        serial_rom_strap_enable,// ROM enable strap pin
  input  wire logic        serial_rom_clock_in,    // Serial clock pin level
  output logic             serial_rom_clock_out,   // Serial clock drive
  output logic             serial_rom_clock_oe,    // Serial clock enable
  output logic             serial_rom_dout,        // Data to ROM
  output logic             serial_rom_dout_oe,     // Data to ROM enable
  output logic             serial_rom_select,      // ROM chip select
  output logic             serial_rom_select_oe,   // Chip select enable
  input  wire logic        serial_rom_din,         // Data from ROM / width strap
  input  wire logic        addr_qualifier_n,       // Host address qualifier
  input  wire logic        write_strobe_n,         // Host write strobe
  input  wire logic        read_strobe_n,          // Host read strobe
  input  wire logic        chip_powerdown_n,       // Power-down request, low active
  output logic             host_write_accept,      // Qualified write pulse
  output logic             host_read_accept,       // Qualified read pulse
  output strap_s           strap_out,              // Latched straps
  output logic             config_ready            // Straps and load complete
);

  logic [6:0]              sync1;
  logic [6:0]              sync2;
  logic                    powerdown;
  logic                    wr_prev;
  logic                    rd_prev;
  cfg_state_e              state;
  strap_s                  strap;
  logic [1:0]              settle_cnt;
  logic [1:0]              word_idx;
  logic [1:0]              bus_speed;
  logic [9:0]              half_cycles;
  logic [ROM_WORD_BITS-1:0] cfg_mem [CFG_WORDS];
  logic [1:0]              host_seen;
  logic                    rd_start;
  logic                    rd_sk;
  logic                    rd_cs;
  logic                    rd_dout;
  logic                    rd_done;
  logic [ROM_WORD_BITS-1:0] rd_data;
  logic                    apb_access;
  logic                    apb_commit;
  logic                    reload_req;
  logic                    wr_fall;
  logic                    rd_fall;
  logic                    decode_ok;
  logic [31:0]             next_prdata;
  logic                    next_pslverr;

  // Two-stage synchronisers for every pin input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= SYNC_RESET;
      sync2 <= SYNC_RESET;
    end else begin
      sync1 <= {serial_rom_strap_enable, serial_rom_clock_in, serial_rom_din,
                addr_qualifier_n, write_strobe_n, read_strobe_n, chip_powerdown_n};
      sync2 <= sync1;
    end
  end

  assign powerdown = !sync2[0];

  // Serial clock half period from bus speed code
  always_comb begin
    case (bus_speed)
      SPEED_125MHZ: half_cycles = SK_FAST_HALF;
      SPEED_25MHZ:  half_cycles = SK_SLOW_HALF;
      default:      half_cycles = SK_SLOW_HALF;
    endcase
  end

  // APB phase decode
  assign apb_access = psel && penable;
  assign apb_commit = apb_access && pready;
  assign reload_req = apb_commit && pwrite && (paddr == ADDR_CTRL) && pwdata[CTRL_RELOAD_BIT];

  // Load sequencer: strap capture, word reads, ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ST_STRAP;
      strap      <= '0;
      settle_cnt <= 2'h0;
      word_idx   <= 2'h0;
      rd_start   <= 1'b0;
    end else begin
      rd_start <= 1'b0;
      if (powerdown) begin
        state      <= ST_STRAP;
        settle_cnt <= 2'h0;
      end else begin
        case (state)
          ST_STRAP: begin
            if (settle_cnt == STRAP_SETTLE) begin
              strap.rom_enable <= sync2[6];
              strap.big_endian <= sync2[5];
              strap.bus16      <= sync2[4];
              word_idx         <= 2'h0;
              state            <= ST_LOAD;
            end else begin
              settle_cnt <= settle_cnt + 2'h1;
            end
          end
          ST_LOAD: begin
            if (!strap.rom_enable) begin
              state <= ST_READY;
            end else begin
              rd_start <= 1'b1;
              state    <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            if (rd_done) begin
              if (word_idx == 2'(CFG_WORDS - 1)) begin
                state <= ST_READY;
              end else begin
                word_idx <= word_idx + 2'h1;
                state    <= ST_LOAD;
              end
            end
          end
          ST_READY: begin
            if (reload_req && strap.rom_enable) begin
              word_idx <= 2'h0;
              state    <= ST_LOAD;
            end
          end
          default: state <= ST_STRAP;
        endcase
      end
    end
  end

  // Configuration word store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < CFG_WORDS; i++) begin
        cfg_mem[i] <= '0;
      end
    end else if (rd_done && (state == ST_WAIT)) begin
      cfg_mem[word_idx] <= rd_data;
    end
  end

  serial_rom_reader u_reader (
    .pclk        (pclk),
    .presetn     (presetn),
    .start       (rd_start),
    .abort       (powerdown),
    .word_addr   ({{(ROM_ADDR_BITS-2){1'b0}}, word_idx}),
    .half_cycles (half_cycles),
    .din         (sync2[4]),
    .sk          (rd_sk),
    .cs          (rd_cs),
    .dout        (rd_dout),
    .done        (rd_done),
    .data        (rd_data)
  );

  // Pin drivers, all released during power-down and before straps are taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_rom_clock_out <= 1'b0;
      serial_rom_clock_oe  <= 1'b0;
      serial_rom_dout      <= 1'b0;
      serial_rom_dout_oe   <= 1'b0;
      serial_rom_select    <= 1'b0;
      serial_rom_select_oe <= 1'b0;
    end else begin
      serial_rom_clock_out <= rd_sk;
      serial_rom_dout      <= rd_dout;
      serial_rom_select    <= rd_cs;
      serial_rom_clock_oe  <= !powerdown && (state != ST_STRAP) && strap.rom_enable;
      serial_rom_dout_oe   <= !powerdown && (state != ST_STRAP) && strap.rom_enable;
      serial_rom_select_oe <= !powerdown && (state != ST_STRAP);
    end
  end

  // Host strobe edges, qualified by address qualifier, readiness and power
  assign decode_ok = !sync2[3] && (state == ST_READY) && !powerdown;
  assign wr_fall   = wr_prev && !sync2[2];
  assign rd_fall   = rd_prev && !sync2[1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_prev           <= 1'b1;
      rd_prev           <= 1'b1;
      host_write_accept <= 1'b0;
      host_read_accept  <= 1'b0;
    end else begin
      wr_prev           <= sync2[2];
      rd_prev           <= sync2[1];
      host_write_accept <= wr_fall && decode_ok;
      host_read_accept  <= rd_fall && decode_ok;
    end
  end

  // Sticky host event flags, set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_seen <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (apb_commit && pwrite && (paddr == ADDR_HOST) && pwdata[i]) begin
          host_seen[i] <= 1'b0;
        end
      end
      if (wr_fall && decode_ok) begin
        host_seen[HOST_WR_BIT] <= 1'b1;
      end
      if (rd_fall && decode_ok) begin
        host_seen[HOST_RD_BIT] <= 1'b1;
      end
    end
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_speed <= CTRL_SPEED_RESET;
    end else if (apb_commit && pwrite && (paddr == ADDR_CTRL)) begin
      bus_speed <= pwdata[CTRL_SPEED_LSB +: 2];
    end
  end

  // Read data and error decode
  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (paddr == ADDR_CTRL) begin
      next_prdata[CTRL_SPEED_LSB +: 2] = bus_speed;
    end else if (paddr == ADDR_STATUS) begin
      next_prdata[STAT_ROM_EN_BIT]  = strap.rom_enable;
      next_prdata[STAT_BIG_END_BIT] = strap.big_endian;
      next_prdata[STAT_BUS16_BIT]   = strap.bus16;
      next_prdata[STAT_READY_BIT]   = (state == ST_READY);
      next_prdata[STAT_BUSY_BIT]    = (state == ST_LOAD) || (state == ST_WAIT);
      next_prdata[STAT_POWERDOWN_BIT] = powerdown;
    end else if (paddr == ADDR_HOST) begin
      next_prdata[1:0] = host_seen;
    end else if ((paddr[11:4] == ADDR_CFG_BASE[11:4]) && (paddr[1:0] == 2'h0)) begin
      next_prdata[ROM_WORD_BITS-1:0] = cfg_mem[paddr[3:2]];
    end else begin
      next_pslverr = 1'b1;
    end
  end

  // APB answer: one wait state, then ready for one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_access && !pready;
      pslverr <= apb_access && !pready && next_pslverr;
      if (apb_access && !pready && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // Status outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_out    <= '0;
      config_ready <= 1'b0;
    end else begin
      strap_out    <= strap;
      config_ready <= (state == ST_READY) && !powerdown;
    end
  end

endmodule : strap_and_eeprom_config

// ---- core/strap_cfg_pkg.sv ----
// Constants, types and register map of the strap and serial ROM configuration loader
package strap_cfg_pkg;

  // Register byte offsets
  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_STATUS    = 12'h004;
  localparam logic [11:0] ADDR_HOST      = 12'h008;
  localparam logic [11:0] ADDR_CFG_BASE  = 12'h010;

  // Control register fields
  localparam int          CTRL_SPEED_LSB  = 0;
  localparam int          CTRL_RELOAD_BIT = 8;
  localparam logic [1:0]  CTRL_SPEED_RESET = 2'h3;
  localparam logic [1:0]  SPEED_25MHZ     = 2'h3;
  localparam logic [1:0]  SPEED_125MHZ    = 2'h0;

  // Status register fields
  localparam int          STAT_ROM_EN_BIT = 0;
  localparam int          STAT_BIG_END_BIT = 1;
  localparam int          STAT_BUS16_BIT  = 2;
  localparam int          STAT_READY_BIT  = 3;
  localparam int          STAT_BUSY_BIT   = 4;
  localparam int          STAT_POWERDOWN_BIT = 5;

  // Host event register fields
  localparam int          HOST_WR_BIT     = 0;
  localparam int          HOST_RD_BIT     = 1;

  // Serial ROM organisation and command
  localparam int          CFG_WORDS       = 4;
  localparam int          ROM_WORD_BITS   = 16;
  localparam int          ROM_ADDR_BITS   = 6;
  localparam logic [2:0]  ROM_READ_CMD    = 3'h6;
  localparam int          ROM_CMD_BITS    = 3 + ROM_ADDR_BITS;
  localparam int          ROM_FRAME_BITS  = ROM_CMD_BITS + ROM_WORD_BITS;

  // Timing: clock period and serial clock cycles
  localparam int          PCLK_PERIOD_NS  = 4;
  localparam int          SK_SLOW_NS      = 4000;
  localparam int          SK_FAST_NS      = 800;
  localparam logic [9:0]  SK_SLOW_HALF    = 10'(SK_SLOW_NS / (2 * PCLK_PERIOD_NS));
  localparam logic [9:0]  SK_FAST_HALF    = 10'(SK_FAST_NS / (2 * PCLK_PERIOD_NS));
  localparam logic [1:0]  STRAP_SETTLE    = 2'h3;

  // Synchroniser reset: strobes, qualifier and power-down idle high
  localparam logic [6:0]  SYNC_RESET      = 7'h0F;

  // Latched strap values
  typedef struct packed {
    logic rom_enable;
    logic big_endian;
    logic bus16;
  } strap_s;

  // Loader sequence
  typedef enum logic [2:0] {
    ST_STRAP = 3'b000,
    ST_LOAD  = 3'b001,
    ST_WAIT  = 3'b010,
    ST_READY = 3'b011
  } cfg_state_e;

  // Serial word reader sequence
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_LOW  = 2'b01,
    RD_HIGH = 2'b10
  } rd_state_e;

endpackage : strap_cfg_pkg

// ---- sim/serial_rom_model.sv ----
// Behavioural serial configuration ROM answering single-word reads
`timescale 1ns/100ps
module serial_rom_model #(
  parameter logic [63:0] IMAGE = 64'h0 // Four words, word 0 lowest
) (
  input  wire logic       sk,          // Clock line
  input  wire logic       cs,          // Select line
  input  wire logic       di,          // Data into ROM
  input  wire logic       pull_level,  // Board pull on data out
  output logic            do_line,     // Data out of ROM
  output logic [7:0]      frames,      // Complete frames
  output logic [5:0]      last_addr,   // Last word address
  output logic            cmd_err      // Bad command seen
);
  logic [4:0] bitn;  // Clock count in frame
  logic [7:0] cmd;   // Shifted command
  logic       drive; // Data phase reached
  logic       dbit;  // Current data bit
  initial begin
    {frames, last_addr, cmd_err, bitn, cmd, drive, dbit} = '0;
  end
  // Command taken and data launched on rising clock; deselect ends the frame
  always @(posedge sk or negedge cs) begin
    if (cs !== 1'b1) begin
      if (bitn == 5'h19)
        frames <= frames + 8'h01;
      bitn <= 5'h00;
      drive <= 1'b0;
    end else begin
      cmd <= {cmd[6:0], di};
      if (bitn == 5'h08) begin
        last_addr <= {cmd[4:0], di};
        if (cmd[7:5] != 3'h6)
          cmd_err <= 1'b1;
      end
      if (bitn >= 5'h09 && bitn <= 5'h18) begin
        drive <= 1'b1;
        dbit <= IMAGE[{last_addr[1:0], 4'(24 - bitn)}];
      end
      bitn <= bitn + 5'h01;
    end
  end
  // Released line settles to the board pull
  assign do_line = (cs && drive) ? dbit : pull_level;
endmodule : serial_rom_model

// ---- sim/strap_and_eeprom_config_chk.sv ----
// Port checker of the strap and serial ROM configuration loader
`timescale 1ns/100ps
module strap_and_eeprom_config_chk
  import strap_cfg_pkg::*;
(
  input wire logic   pclk,                 // Clock
  input wire logic   presetn,              // Reset
  input wire logic   psel,                 // APB select
  input wire logic   penable,              // APB enable
  input wire logic   pready,               // APB ready
  input wire logic   pslverr,              // APB error
  input wire logic   serial_rom_clock_out, // Serial clock
  input wire logic   serial_rom_clock_oe,  // Clock enable
  input wire logic   serial_rom_dout_oe,   // Data enable
  input wire logic   serial_rom_select,    // Select
  input wire logic   serial_rom_select_oe, // Select enable
  input wire logic   addr_qualifier_n,     // Qualifier
  input wire logic   write_strobe_n,       // Write strobe
  input wire logic   chip_powerdown_n,     // Power-down
  input wire logic   host_write_accept,    // Write pulse
  input wire logic   host_read_accept,     // Read pulse
  input wire strap_s strap_out,            // Straps
  input wire logic   config_ready          // Ready
);
  logic [9:0] hold_cnt; // Cycles level stood
  logic       sk_prev;  // Clock one cycle back
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Measure serial clock half periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt <= 10'h000;
      sk_prev <= 1'b0;
    end else begin
      hold_cnt <= (serial_rom_clock_out != sk_prev) ? 10'h001 : hold_cnt + 10'h001;
      sk_prev <= serial_rom_clock_out;
    end
  end
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready not after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_sk_half: assert property (
    serial_rom_select && sk_prev && !serial_rom_clock_out |-> hold_cnt == SK_FAST_HALF || hold_cnt == SK_SLOW_HALF)
    else $error("serial clock high half wrong");
  a_select_frame: assert property (
    $rose(serial_rom_select) |-> serial_rom_select_oe && serial_rom_clock_oe && !serial_rom_clock_out)
    else $error("select rose outside a frame start");
  a_pd_release: assert property (
    !chip_powerdown_n [*5] |-> !serial_rom_clock_oe && !serial_rom_dout_oe && !serial_rom_select_oe && !config_ready)
    else $error("pins driven in power-down");
  a_no_rom_quiet: assert property (
    !strap_out.rom_enable && config_ready |-> !serial_rom_select && !serial_rom_clock_oe)
    else $error("serial ROM used while absent");
  a_qual_block: assert property (
    addr_qualifier_n [*6] |-> !host_write_accept && !host_read_accept)
    else $error("strobe accepted while unqualified");
  a_wr_accept: assert property (
    $fell(write_strobe_n) && !addr_qualifier_n && config_ready && chip_powerdown_n |-> ##[1:5] host_write_accept)
    else $error("write strobe not accepted");
  a_rd_pulse: assert property (host_read_accept |=> !host_read_accept)
    else $error("read accept longer than one cycle");
endmodule : strap_and_eeprom_config_chk

bind strap_and_eeprom_config strap_and_eeprom_config_chk i_chk (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .serial_rom_clock_out, .serial_rom_clock_oe, .serial_rom_dout_oe, .serial_rom_select,
  .serial_rom_select_oe, .addr_qualifier_n, .write_strobe_n, .chip_powerdown_n, .host_write_accept,
  .host_read_accept, .strap_out, .config_ready);

// ---- sim/strap_and_eeprom_config_tb.sv ----
// Self-checking bench of the strap and serial ROM configuration loader
`timescale 1ns/100ps
module strap_and_eeprom_config_tb;
  import strap_cfg_pkg::*;
  localparam logic [63:0] IMAGE = 64'h8001_0FF0_5A3C_C3A5; // Word 0 lowest
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        serial_rom_strap_enable, serial_rom_clock_in, serial_rom_clock_out, serial_rom_clock_oe;
  logic        serial_rom_dout, serial_rom_dout_oe, serial_rom_select, serial_rom_select_oe, serial_rom_din;
  logic        addr_qualifier_n, write_strobe_n, read_strobe_n, chip_powerdown_n, sk_pull, din_pull;
  logic        host_write_accept, host_read_accept, config_ready, cmd_err;
  strap_s      strap_out;
  logic [7:0]  frames;
  logic [5:0]  last_addr;
  int          failures = 0, checks = 0, wr_pulses = 0, rd_pulses = 0;

  // Clock pin level from drive or strap pull
  assign serial_rom_clock_in = serial_rom_clock_oe ? serial_rom_clock_out : sk_pull;

  strap_and_eeprom_config i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .serial_rom_strap_enable, .serial_rom_clock_in, .serial_rom_clock_out,
    .serial_rom_clock_oe, .serial_rom_dout, .serial_rom_dout_oe, .serial_rom_select,
    .serial_rom_select_oe, .serial_rom_din, .addr_qualifier_n, .write_strobe_n, .read_strobe_n,
    .chip_powerdown_n, .host_write_accept, .host_read_accept, .strap_out, .config_ready);

  serial_rom_model #(.IMAGE(IMAGE)) i_rom (.sk(serial_rom_clock_in), .cs(serial_rom_select_oe & serial_rom_select),
    .di(serial_rom_dout_oe & serial_rom_dout), .pull_level(din_pull), .do_line(serial_rom_din),
    .frames, .last_addr(), .cmd_err);

  // Clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Count accept pulses
  always @(posedge pclk) begin
    if (host_write_accept === 1'b1) wr_pulses++;
    if (host_read_accept === 1'b1) rd_pulses++;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One APB transfer, result left in rd and err
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("apb answer", 32'h1, {31'h0, pready});
  endtask : apb

  // One host strobe with the qualifier at level q
  task automatic strobe(input logic wr, input logic q);
    @(posedge pclk);
    addr_qualifier_n <= q;
    repeat (4) @(posedge pclk);
    if (wr) write_strobe_n <= 1'b0;
    else read_strobe_n <= 1'b0;
    repeat (8) @(posedge pclk);
    write_strobe_n <= 1'b1;
    read_strobe_n <= 1'b1;
    repeat (8) @(posedge pclk);
    addr_qualifier_n <= 1'b1;
  endtask : strobe

  task automatic wait_ready(input int lim);
    int n;
    n = 0;
    while (config_ready !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    check("ready", 32'h1, {31'h0, config_ready});
  endtask : wait_ready

  task automatic sk_period(input int exp_ns);
    realtime t0;
    @(posedge serial_rom_clock_out);
    t0 = $realtime;
    @(posedge serial_rom_clock_out);
    check("sk period ns", 32'(exp_ns), 32'(int'($realtime - t0)));
  endtask : sk_period

  task automatic print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // Watchdog
  initial begin
    #200000;
    failures++;
    print_verdict();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {serial_rom_strap_enable, sk_pull, din_pull} = 3'h7;
    {addr_qualifier_n, write_strobe_n, read_strobe_n, chip_powerdown_n} = 4'hF;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Fast load from ROM, strobe refused meanwhile
    apb(ADDR_CTRL, 1'b1, 32'h0);
    sk_period(SK_FAST_NS);
    strobe(1'b1, 1'b0);
    wait_ready(40000);
    check("early strobe", 32'h0, wr_pulses);
    for (int i = 0; i < CFG_WORDS; i++) begin
      apb(ADDR_CFG_BASE + 12'(4 * i), 1'b0, 32'h0);
      check("cfg word", {16'h0, IMAGE[16*i +: 16]}, rd);
    end
    check("frames", 32'h4, {24'h0, frames});
    check("frame command", 32'h0, {31'h0, cmd_err});
    apb(ADDR_STATUS, 1'b0, 32'h0);
    check("status", 32'h0F, rd);
    apb(12'h020, 1'b0, 32'h0);
    check("unmapped", 32'h1, {31'h0, err});
    $display("test fast load done");
    // Slow reload, then power-down with new straps
    apb(ADDR_CTRL, 1'b1, 32'h103);
    sk_period(SK_SLOW_NS);
    {serial_rom_strap_enable, sk_pull, din_pull} <= 3'h1;
    chip_powerdown_n <= 1'b0;
    repeat (10) @(posedge pclk);
    check("pins released", 32'h0, {28'h0, serial_rom_clock_oe, serial_rom_dout_oe, serial_rom_select_oe,
      config_ready});
    chip_powerdown_n <= 1'b1;
    wait_ready(200);
    check("straps", 32'h1, {29'h0, strap_out});
    check("no frame", 32'h4, {24'h0, frames});
    $display("test power-down done");
    // Host strobes
    strobe(1'b1, 1'b0);
    strobe(1'b1, 1'b1);
    strobe(1'b0, 1'b0);
    check("writes", 32'h1, wr_pulses);
    check("reads", 32'h1, rd_pulses);
    apb(ADDR_HOST, 1'b0, 32'h0);
    check("host events", 32'h3, rd);
    apb(ADDR_HOST, 1'b1, 32'h3);
    apb(ADDR_HOST, 1'b0, 32'h0);
    check("host cleared", 32'h0, rd);
    $display("test strobes done");
    print_verdict();
  end
endmodule : strap_and_eeprom_config_tb
